//--- verilog/ckm_mailbox_regs.sv
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Segment one lasts programmed value plus one
// - Page field picks filter banks or config
// - Receive mailbox ignores every software write
// - Transmit mailbox writable only while empty
// - Error flag updated after each attempt
// - Arbitration lost flag updated each attempt
// - Success flag updated, mirrored in status
// - Done flag set, cleared by one/request
// - Clearing done clears all attempt flags
// - Abort only acts on pending request
// - Send request cleared when mailbox empties
// - Receive mailbox shows read-only match index
// - Identifier bits packed over four bytes
// - Identifier byte zero holds type bits
// - Time-triggered mode sends captured stamp
// - Four-bit length, bits six:four zero
// - Length and data locked unless empty
// - Eight data byte registers per mailbox
// - Start of frame captures sixteen-bit timer
// - Config byte holds two filters' fields
// - Active bit enables; clear before editing
// - Quantum is prescaler plus one clocks
// - Done flag raises enabled interrupt line
module ckm_mailbox_regs (
	// System
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// Register port
	input wire ckm_pkg::ckm_bus_s bus_i,
	output logic [7:0] rdata_o,
	// Protocol engine events
	input wire logic bit_start_i,
	input wire logic sof_i,
	input wire logic [15:0] timer_i,
	input wire logic tx_att_i,
	input wire ckm_pkg::ckm_att_s tx_res_i,
	input wire logic abort_done_i,
	input wire logic rx_store_i,
	input wire ckm_pkg::ckm_msg_s rx_msg_i,
	input wire logic [7:0] rx_index_i,
	// Protocol engine controls
	output logic tx_request_o,
	output logic tx_abort_o,
	output ckm_pkg::ckm_msg_s tx_msg_o,
	output logic send_global_time_o,
	output logic tx_done_irq_o,
	output logic tq_tick_o,
	output logic seg1_end_o,
	// Filter setup
	output logic [2:0] filter_page_sel_o,
	output ckm_pkg::ckm_fcfg_s [3:0] filter_cfg_o
);

	typedef struct packed {
		logic [7:0] rdata;
		logic time_trigger_mode;
		logic mailbox_empty_irq_en;
		logic [ckm_pkg::PRESC_W-1:0] quantum_prescaler;
		logic [ckm_pkg::SEG1_W-1:0] seg_one_len;
		logic [2:0] filter_page_sel;
		ckm_pkg::ckm_cs_s cs;
		ckm_pkg::ckm_msg_s tx;
		ckm_pkg::ckm_msg_s rx;
		logic [7:0] match_filter_number;
		logic [15:0] sof_stamp;
		logic send_global_time;
		logic irq;
	} ckm_top_s;

	ckm_top_s s;
	ckm_top_s next_s;
	ckm_pkg::ckm_cs_s wcs;
	logic [3:0] off;
	logic [3:0] grp;
	logic [1:0] fcfg_wr;
	logic [1:0][7:0] fcfg_byte;
	logic tx_empty;

	// Mailbox read: head byte, length, identifier, stamp, data
	function automatic logic [7:0] mb_rd(input ckm_pkg::ckm_msg_s m, input logic [7:0] head,
		input logic [3:0] o);
		logic [7:0] v;
		logic [1:0] ix;
		v = 8'h00;
		ix = 2'(o[1:0] + ckm_pkg::ID_SHIFT);
		if (o[3])
			v = m.mailbox_data_bytes[o[2:0]];
		else
		begin
			case (o)
				ckm_pkg::O_HEAD: v = head;
				ckm_pkg::O_DLC: v = m.mailbox_length_ctrl;
				ckm_pkg::O_STL: v = m.stamp[7:0];
				ckm_pkg::O_STH: v = m.stamp[15:8];
				default: v = m.mailbox_identifier[ix];
			endcase
		end
		return v;
	endfunction

	assign wcs = ckm_pkg::ckm_cs_s'(bus_i.wdata);
	assign off = bus_i.addr[3:0];
	assign grp = bus_i.addr[7:4];
	assign tx_empty = !s.cs.send_request_bit;

	// config window only on high pages
	always_comb
	begin
		fcfg_wr[0] = bus_i.wr && bus_i.addr == {ckm_pkg::G_WIN, 4'h0}
			&& s.filter_page_sel >= ckm_pkg::PAGE_CFG;
		fcfg_wr[1] = bus_i.wr && bus_i.addr == {ckm_pkg::G_WIN, 4'h1}
			&& s.filter_page_sel >= ckm_pkg::PAGE_CFG;
	end

	// Register file, mailbox flags and engine events in one step
	always_comb
	begin
		next_s = s;
		next_s.rdata = 8'h00;

		// Read path; data stand in the following cycle only
		if (bus_i.rd)
		begin
			case (grp)
				ckm_pkg::G_LOCAL:
				begin
					case (bus_i.addr)
						ckm_pkg::A_CTRL:
							next_s.rdata = {6'h00, s.mailbox_empty_irq_en, s.time_trigger_mode};
						ckm_pkg::A_TIMING0:
							next_s.rdata = {2'h0, s.quantum_prescaler};
						ckm_pkg::A_TIMING1:
							next_s.rdata = {4'h0, s.seg_one_len};
						ckm_pkg::A_TXSTAT:
							next_s.rdata = {6'h00, s.cs.tx_success_flag, s.cs.request_done_flag};
						ckm_pkg::A_PAGE:
							next_s.rdata = {5'h00, s.filter_page_sel};
						default:
							next_s.rdata = 8'h00;
					endcase
				end
				ckm_pkg::G_TX:
					next_s.rdata = mb_rd(s.tx, s.cs, off);
				ckm_pkg::G_RX:
					next_s.rdata = mb_rd(s.rx, s.match_filter_number, off);
				ckm_pkg::G_WIN:
				begin
					if (s.filter_page_sel >= ckm_pkg::PAGE_CFG && off[3:1] == 3'h0)
						next_s.rdata = fcfg_byte[off[0]];
				end
				default:
					next_s.rdata = 8'h00;
			endcase
		end

		// Software writes
		if (bus_i.wr)
		begin
			case (grp)
				ckm_pkg::G_LOCAL:
				begin
					case (bus_i.addr)
						ckm_pkg::A_CTRL:
						begin
							next_s.time_trigger_mode = bus_i.wdata[0];
							next_s.mailbox_empty_irq_en = bus_i.wdata[1];
						end
						ckm_pkg::A_TIMING0:
							next_s.quantum_prescaler = bus_i.wdata[ckm_pkg::PRESC_W-1:0];
						ckm_pkg::A_TIMING1:
							next_s.seg_one_len = bus_i.wdata[ckm_pkg::SEG1_W-1:0];
						ckm_pkg::A_PAGE:
							next_s.filter_page_sel = bus_i.wdata[2:0];
						default:
							next_s.rdata = next_s.rdata;
					endcase
				end
				ckm_pkg::G_TX:
				begin
					if (off == ckm_pkg::O_HEAD)
					begin
						if (wcs.request_done_flag)
						begin
							next_s.cs.request_done_flag = 1'b0;
							next_s.cs.tx_success_flag = 1'b0;
							next_s.cs.arbitration_lost_flag = 1'b0;
							next_s.cs.tx_fail_flag = 1'b0;
						end
						if (wcs.abort_request_bit && s.cs.send_request_bit)
							next_s.cs.abort_request_bit = 1'b1;
						if (wcs.send_request_bit && tx_empty)
						begin
							next_s.cs.send_request_bit = 1'b1;
							next_s.cs.request_done_flag = 1'b0;
							next_s.cs.tx_success_flag = 1'b0;
							next_s.cs.arbitration_lost_flag = 1'b0;
							next_s.cs.tx_fail_flag = 1'b0;
						end
					end
					else if (tx_empty)
					begin
						if (off[3])
							next_s.tx.mailbox_data_bytes[off[2:0]] = bus_i.wdata;
						else
						begin
							case (off)
								ckm_pkg::O_DLC: next_s.tx.mailbox_length_ctrl = bus_i.wdata;
								ckm_pkg::O_STL: next_s.tx.stamp[7:0] = bus_i.wdata;
								ckm_pkg::O_STH: next_s.tx.stamp[15:8] = bus_i.wdata;
								default: next_s.tx.mailbox_identifier[2'(off[1:0] + ckm_pkg::ID_SHIFT)] = bus_i.wdata;
							endcase
						end
					end
				end
				ckm_pkg::G_RX:
					next_s.rx = s.rx;
				default:
					next_s.rx = s.rx;
			endcase
		end

		// Engine events come last so they beat a software write in the same cycle
		if (tx_att_i)
		begin
			next_s.cs.tx_success_flag = tx_res_i.ok;
			next_s.cs.arbitration_lost_flag = tx_res_i.arb_lost && !tx_res_i.ok;
			next_s.cs.tx_fail_flag = tx_res_i.error && !tx_res_i.ok;
			if (tx_res_i.ok)
			begin
				next_s.cs.send_request_bit = 1'b0;
				next_s.cs.abort_request_bit = 1'b0;
				next_s.cs.request_done_flag = 1'b1;
				next_s.tx.stamp = s.sof_stamp;
			end
		end
		if (abort_done_i)
		begin
			next_s.cs.send_request_bit = 1'b0;
			next_s.cs.abort_request_bit = 1'b0;
			next_s.cs.request_done_flag = 1'b1;
		end

		if (sof_i)
			next_s.sof_stamp = timer_i;
		if (rx_store_i)
		begin
			next_s.rx = rx_msg_i;
			next_s.rx.stamp = s.sof_stamp;
			next_s.match_filter_number = rx_index_i;
		end

		next_s.tx.mailbox_identifier[3] = next_s.tx.mailbox_identifier[3] & ckm_pkg::M_ID3;
		next_s.rx.mailbox_identifier[3] = next_s.rx.mailbox_identifier[3] & ckm_pkg::M_ID3;
		// type bits kept, bit seven zero
		next_s.tx.mailbox_identifier[0] = next_s.tx.mailbox_identifier[0] & ckm_pkg::M_ID0;
		next_s.rx.mailbox_identifier[0] = next_s.rx.mailbox_identifier[0] & ckm_pkg::M_ID0;
		next_s.tx.mailbox_length_ctrl = next_s.tx.mailbox_length_ctrl & ckm_pkg::M_DLC;
		next_s.rx.mailbox_length_ctrl = next_s.rx.mailbox_length_ctrl & ckm_pkg::M_DLC;

		// stamp sent only in time-triggered mode
		next_s.send_global_time = next_s.time_trigger_mode
			&& next_s.tx.mailbox_length_ctrl[ckm_pkg::B_TGT];
		next_s.irq = next_s.mailbox_empty_irq_en && next_s.cs.request_done_flag;
	end

	// Reset gives the documented bit-timing default and clears the rest
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			s <= '0;
			s.seg_one_len <= ckm_pkg::R_SEG1;
		end
		else
			s <= next_s;
	end

	// Bit timing counters run from the programmed fields
	ckm_bit_quanta #(
		.PW(ckm_pkg::PRESC_W),
		.SW(ckm_pkg::SEG1_W)
	) u_quanta (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.prescale_i(s.quantum_prescaler),
		.seg_len_i(s.seg_one_len),
		.bit_start_i(bit_start_i),
		.tq_tick_o(tq_tick_o),
		.seg1_end_o(seg1_end_o)
	);

	// One configuration byte per filter pair
	for (genvar g = 0; g < 2; g++)
	begin : g_fp
		ckm_filter_pair u_pair (
			.clk_sys_i(clk_sys_i),
			.resetn_i(resetn_i),
			.wr_i(fcfg_wr[g]),
			.wdata_i(bus_i.wdata),
			.cfg_o(fcfg_byte[g]),
			.even_o(filter_cfg_o[2*g]),
			.odd_o(filter_cfg_o[2*g+1])
		);
	end

	assign rdata_o = s.rdata;
	assign tx_request_o = s.cs.send_request_bit;
	assign tx_abort_o = s.cs.abort_request_bit;
	assign tx_msg_o = s.tx;
	assign send_global_time_o = s.send_global_time;
	assign tx_done_irq_o = s.irq;
	assign filter_page_sel_o = s.filter_page_sel;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);

	logic no_hw;
	assign no_hw = !tx_att_i && !abort_done_i;

	sequence s_head_wr(logic bit_set);
		bus_i.wr && bus_i.addr == {ckm_pkg::G_TX, ckm_pkg::O_HEAD} && bit_set && no_hw;
	endsequence

	a_page_read: assert property (bus_i.rd && bus_i.addr == ckm_pkg::A_PAGE
		|=> rdata_o[7:3] == 5'h00 && rdata_o[2:0] == filter_page_sel_o)
		else $error("page read wrong");
	a_rx_locked: assert property (bus_i.wr && grp == ckm_pkg::G_RX && !rx_store_i
		|=> $stable(s.rx))
		else $error("receive mailbox changed by write");
	a_tx_locked: assert property (bus_i.wr && grp == ckm_pkg::G_TX && off != ckm_pkg::O_HEAD
		&& tx_request_o && !tx_att_i |=> $stable(s.tx))
		else $error("busy mailbox written");
	a_err_flag: assert property (tx_att_i && tx_res_i.error && !tx_res_i.ok
		|=> s.cs.tx_fail_flag && !s.cs.tx_success_flag)
		else $error("error flag not set");
	a_arb_flag: assert property (tx_att_i && tx_res_i.arb_lost && !tx_res_i.ok && !abort_done_i
		|=> s.cs.arbitration_lost_flag && tx_request_o)
		else $error("arbitration flag not set");
	a_ok_done: assert property (tx_att_i && tx_res_i.ok
		|=> s.cs.tx_success_flag && s.cs.request_done_flag && !tx_request_o && tx_done_irq_o == s.mailbox_empty_irq_en)
		else $error("success not reported");
	a_done_clear: assert property (s_head_wr(wcs.request_done_flag)
		|=> !s.cs.request_done_flag && !s.cs.tx_success_flag && !s.cs.arbitration_lost_flag && !s.cs.tx_fail_flag)
		else $error("done clear incomplete");
	a_abort_idle: assert property (s_head_wr(wcs.abort_request_bit && !tx_request_o)
		|=> !tx_abort_o)
		else $error("abort set while idle");
	a_empty_clear: assert property (abort_done_i |=> !tx_request_o && !tx_abort_o
		&& s.cs.request_done_flag)
		else $error("request not cleared");

endmodule

`default_nettype wire

//--- inc/ckm_pkg.sv
package ckm_pkg;

	// Register port addresses: high nibble selects a group, low nibble the offset
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_TIMING0 = 8'h01;
	localparam logic [7:0] A_TIMING1 = 8'h02;
	localparam logic [7:0] A_TXSTAT = 8'h03;
	localparam logic [7:0] A_PAGE = 8'h04;
	localparam logic [3:0] G_LOCAL = 4'h0;
	localparam logic [3:0] G_TX = 4'h1;
	localparam logic [3:0] G_RX = 4'h2;
	localparam logic [3:0] G_WIN = 4'h3;

	// Mailbox offsets; data bytes sit at offsets 8 to 15
	localparam logic [3:0] O_HEAD = 4'h0;
	localparam logic [3:0] O_DLC = 4'h1;
	localparam logic [3:0] O_ID0 = 4'h2;
	localparam logic [3:0] O_STL = 4'h6;
	localparam logic [3:0] O_STH = 4'h7;
	localparam logic [1:0] ID_SHIFT = 2'h2;

	// Field masks and positions
	localparam logic [7:0] M_ID0 = 8'h7f;
	localparam logic [7:0] M_ID3 = 8'hfe;
	localparam logic [7:0] M_DLC = 8'h8f;
	localparam int B_TGT = 7;
	localparam logic [2:0] PAGE_CFG = 3'h4;
	localparam logic [3:0] R_SEG1 = 4'h3;
	localparam int PRESC_W = 6;
	localparam int SEG1_W = 4;
	localparam int DATA_BYTES = 8;

	// Register port, one request per cycle
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ckm_bus_s;

	// Transmit mailbox control and status byte
	typedef struct packed {
		logic [1:0] rsv;
		logic tx_fail_flag;
		logic arbitration_lost_flag;
		logic tx_success_flag;
		logic request_done_flag;
		logic abort_request_bit;
		logic send_request_bit;
	} ckm_cs_s;

	// Outcome of one transmission attempt
	typedef struct packed {
		logic ok;
		logic arb_lost;
		logic error;
	} ckm_att_s;

	// Message image of one mailbox
	typedef struct packed {
		logic [3:0][7:0] mailbox_identifier;
		logic [7:0] mailbox_length_ctrl;
		logic [15:0] stamp;
		logic [DATA_BYTES-1:0][7:0] mailbox_data_bytes;
	} ckm_msg_s;

	// Configuration of one acceptance filter
	typedef struct packed {
		logic fifo_assign_bit;
		logic [1:0] filter_scale_field;
		logic filter_active_bit;
	} ckm_fcfg_s;

endpackage

//--- verilog/ckm_bit_quanta.sv
`timescale 1ns/1ps
`default_nettype none

module ckm_bit_quanta #(
	parameter int PW = 6,
	parameter int SW = 4
) (
	// System
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// Timing setup
	input wire logic [PW-1:0] prescale_i,
	input wire logic [SW-1:0] seg_len_i,
	input wire logic bit_start_i,
	// Timing pulses
	output logic tq_tick_o,
	output logic seg1_end_o
);

	typedef struct packed {
		logic [PW-1:0] pcnt;
		logic [SW-1:0] qcnt;
		logic in_seg;
		logic tick;
		logic seg_end;
	} ckm_bq_s;

	ckm_bq_s s;
	ckm_bq_s next_s;

	// Prescaler and segment counters; a bit start restarts both
	always_comb
	begin
		next_s = s;
		next_s.tick = 1'b0;
		next_s.seg_end = 1'b0;
		if (bit_start_i)
		begin
			next_s.pcnt = '0;
			next_s.qcnt = '0;
			next_s.in_seg = 1'b1;
		end
		else if (s.pcnt == prescale_i)
		begin
			next_s.pcnt = '0;
			next_s.tick = 1'b1;
			if (s.in_seg && s.qcnt == seg_len_i)
			begin
				next_s.in_seg = 1'b0;
				next_s.seg_end = 1'b1;
			end
			else if (s.in_seg)
				next_s.qcnt = SW'(s.qcnt + 1'b1);
		end
		else
			next_s.pcnt = PW'(s.pcnt + 1'b1);
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign tq_tick_o = s.tick;
	assign seg1_end_o = s.seg_end;

	a_seg_end_count: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		seg1_end_o |-> tq_tick_o && $past(s.qcnt) == $past(seg_len_i))
		else $error("segment one ended at wrong quantum");

endmodule

`default_nettype wire

//--- verilog/ckm_filter_pair.sv
`timescale 1ns/1ps
`default_nettype none

module ckm_filter_pair (
	// System
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// Register write
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	// Stored byte and decoded filters
	output logic [7:0] cfg_o,
	output ckm_pkg::ckm_fcfg_s even_o,
	output ckm_pkg::ckm_fcfg_s odd_o
);

	typedef struct packed {
		ckm_pkg::ckm_fcfg_s odd;
		ckm_pkg::ckm_fcfg_s even;
	} ckm_fp_s;

	ckm_fp_s s;
	ckm_fp_s next_s;

	always_comb
	begin
		next_s = s;
		if (wr_i)
			next_s = ckm_fp_s'(wdata_i);
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign cfg_o = s;
	assign even_o = s.even;
	assign odd_o = s.odd;

	a_cfg_store: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		wr_i |=> cfg_o == $past(wdata_i) && odd_o.filter_scale_field == $past(wdata_i[6:5]))
		else $error("filter config byte not stored unchanged");

endmodule

`default_nettype wire

//--- verif/ckm_engine_model.sv
`timescale 1ns/1ps
`default_nettype none

// Protocol engine stand-in: raises the events the mailbox logic reacts to
module ckm_engine_model (
	// System
	input wire logic clk_sys_i,
	// Mailbox state seen by the engine
	input wire logic tx_request_i,
	input wire logic tx_abort_i,
	// Engine events
	output logic bit_start_o,
	output logic sof_o,
	output logic [15:0] timer_o,
	output logic tx_att_o,
	output ckm_pkg::ckm_att_s tx_res_o,
	output logic abort_done_o,
	output logic rx_store_o,
	output ckm_pkg::ckm_msg_s rx_msg_o,
	output logic [7:0] rx_index_o
);
	// Quiet strobes at time zero; data lines carry nothing until their first pulse
	initial
	begin
		{bit_start_o, sof_o, tx_att_o, abort_done_o, rx_store_o} = 5'h00;
	end

	// Bit boundary pulse
	task automatic bit_begin();
		@(posedge clk_sys_i);
		bit_start_o <= 1'b1;
		@(posedge clk_sys_i);
		bit_start_o <= 1'b0;
	endtask

	// Timer value is only meaningful beside the pulse, so it is scrambled after
	task automatic frame_start(input logic [15:0] t);
		@(posedge clk_sys_i);
		sof_o <= 1'b1;
		timer_o <= t;
		@(posedge clk_sys_i);
		sof_o <= 1'b0;
		timer_o <= ~t;
	endtask

	// engine only tries a pending mailbox
	task automatic attempt(input ckm_pkg::ckm_att_s r);
		@(posedge clk_sys_i);
		tx_att_o <= tx_request_i;
		tx_res_o <= r;
		@(posedge clk_sys_i);
		tx_att_o <= 1'b0;
		tx_res_o <= ~r;
	endtask

	// abort completes only while a request is pending
	task automatic abort_finish();
		@(posedge clk_sys_i);
		abort_done_o <= tx_request_i & tx_abort_i;
		@(posedge clk_sys_i);
		abort_done_o <= 1'b0;
	endtask

	// Reception store; message lines hold garbage outside the pulse
	task automatic store(input ckm_pkg::ckm_msg_s m, input logic [7:0] idx);
		@(posedge clk_sys_i);
		rx_store_o <= 1'b1;
		rx_msg_o <= m;
		rx_index_o <= idx;
		@(posedge clk_sys_i);
		rx_store_o <= 1'b0;
		rx_msg_o <= ~m;
		rx_index_o <= ~idx;
	endtask
endmodule

`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic clk_sys_i;
	logic resetn_i;
	ckm_pkg::ckm_bus_s bus;
	logic [7:0] rdata;
	logic bit_start, sof, tx_att, abort_done, rx_store;
	logic [15:0] timer;
	ckm_pkg::ckm_att_s tx_res;
	ckm_pkg::ckm_msg_s rx_msg, tx_msg, msg;
	logic [7:0] rx_index;
	logic tx_request, tx_abort, sgt, irq, tq_tick, seg1_end;
	logic [2:0] page;
	ckm_pkg::ckm_fcfg_s [3:0] fcfg;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	int ticks = 0;
	int seg_ticks = 99;
	int last_tick = 0;
	int spacing = 0;

	ckm_mailbox_regs dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .bus_i(bus), .rdata_o(rdata),
		.bit_start_i(bit_start), .sof_i(sof), .timer_i(timer), .tx_att_i(tx_att), .tx_res_i(tx_res),
		.abort_done_i(abort_done), .rx_store_i(rx_store), .rx_msg_i(rx_msg), .rx_index_i(rx_index),
		.tx_request_o(tx_request), .tx_abort_o(tx_abort), .tx_msg_o(tx_msg), .send_global_time_o(sgt),
		.tx_done_irq_o(irq), .tq_tick_o(tq_tick), .seg1_end_o(seg1_end), .filter_page_sel_o(page),
		.filter_cfg_o(fcfg));

	ckm_engine_model eng (.clk_sys_i(clk_sys_i), .tx_request_i(tx_request), .tx_abort_i(tx_abort),
		.bit_start_o(bit_start), .sof_o(sof), .timer_o(timer), .tx_att_o(tx_att), .tx_res_o(tx_res),
		.abort_done_o(abort_done), .rx_store_o(rx_store), .rx_msg_o(rx_msg), .rx_index_o(rx_index));

	// 100 MHz system clock
	initial
	begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Bus cycles hold one idle cycle between requests so no signal is driven twice in a step
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys_i);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys_i);
		bus <= '0;
		#1;
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys_i);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys_i);
		bus <= '0;
		#1;
		chk($sformatf("register %h", a), rdata, exp);
	endtask

	task automatic tdone(input string name);
		$display("test %s finished after %0d comparisons", name, cmp_count);
	endtask

	// Quantum and segment watcher; also cuts a hung run short
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (bit_start === 1'b1)
		begin
			ticks = 0;
			seg_ticks = -1;
		end
		else
		begin
			if (tq_tick === 1'b1)
			begin
				ticks++;
				spacing = cyc - last_tick;
				last_tick = cyc;
			end
			if (seg1_end === 1'b1 && seg_ticks < 0)
				seg_ticks = ticks;
		end
		if (cyc == 5000)
		begin
			n_errors++;
			end_of_test();
		end
	end

	initial
	begin
		resetn_i = 1'b0;
		bus = '0;
		repeat (8) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		// Reset values, page field and the filter window
		rc(8'h04, 8'h00);
		rc(8'h10, 8'h00);
		rc(8'h20, 8'h00);
		rc(8'h03, 8'h00);
		rc(8'h02, 8'h03);
		wr(8'h04, 8'hff);
		rc(8'h04, 8'h07);
		chk("page out", {5'h00, page}, 8'h07);
		// fifo, scale and active bits set; filters 0 and 3 come out active
		wr(8'h30, 8'ha5);
		wr(8'h31, 8'h3c);
		rc(8'h30, 8'ha5);
		rc(8'h31, 8'h3c);
		chk("filters 1 0", {fcfg[1], fcfg[0]}, 8'ha5);
		chk("filters 3 2", {fcfg[3], fcfg[2]}, 8'h3c);
		wr(8'h04, 8'h03);
		wr(8'h30, 8'h00);
		rc(8'h30, 8'h00);
		wr(8'h04, 8'h04);
		rc(8'h30, 8'ha5);
		tdone("filters");
		// Fill the transmit mailbox, reserved bits must read zero
		wr(8'h12, 8'he5);
		wr(8'h15, 8'hff);
		wr(8'h11, 8'hff);
		rc(8'h12, 8'h65);
		rc(8'h15, 8'hfe);
		rc(8'h11, 8'h8f);
		chk("global time off", {7'h00, sgt}, 8'h00);
		wr(8'h00, 8'h03);
		chk("global time on", {7'h00, sgt}, 8'h01);
		rc(8'h00, 8'h03);
		for (int i = 0; i < 8; i++)
			wr(8'h18 + 8'(i), 8'h11 * 8'(i) + 8'h01);
		for (int i = 0; i < 8; i++)
			rc(8'h18 + 8'(i), 8'h11 * 8'(i) + 8'h01);
		chk("tx byte 7", tx_msg.mailbox_data_bytes[7], 8'h78);
		tdone("fill");
		// Locked while pending, then arbitration loss, error and success
		wr(8'h10, 8'h01);
		chk("request", {7'h00, tx_request}, 8'h01);
		wr(8'h11, 8'h02);
		wr(8'h18, 8'h00);
		wr(8'h12, 8'h00);
		rc(8'h11, 8'h8f);
		rc(8'h18, 8'h01);
		rc(8'h12, 8'h65);
		eng.attempt(3'h2);
		rc(8'h10, 8'h11);
		eng.attempt(3'h1);
		rc(8'h10, 8'h21);
		eng.frame_start(16'h1234);
		eng.attempt(3'h4);
		rc(8'h10, 8'h0c);
		rc(8'h03, 8'h03);
		chk("done irq", {7'h00, irq}, 8'h01);
		rc(8'h16, 8'h34);
		rc(8'h17, 8'h12);
		wr(8'h10, 8'h04);
		rc(8'h10, 8'h00);
		rc(8'h03, 8'h00);
		chk("irq cleared", {7'h00, irq}, 8'h00);
		tdone("send");
		// Abort with nothing pending, then a real abort
		wr(8'h10, 8'h02);
		rc(8'h10, 8'h00);
		wr(8'h10, 8'h01);
		wr(8'h10, 8'h03);
		chk("abort", {7'h00, tx_abort}, 8'h01);
		eng.abort_finish();
		rc(8'h10, 8'h04);
		chk("request gone", {7'h00, tx_request}, 8'h00);
		wr(8'h10, 8'h01);
		rc(8'h10, 8'h01);
		eng.attempt(3'h4);
		wr(8'h10, 8'h04);
		tdone("abort");
		// Receive mailbox: software writes refused
		wr(8'h20, 8'h55);
		rc(8'h20, 8'h00);
		eng.frame_start(16'hbeef);
		msg = '0;
		msg.mailbox_identifier[0] = 8'h45;
		msg.mailbox_data_bytes[0] = 8'h9a;
		eng.store(msg, 8'h2a);
		rc(8'h20, 8'h2a);
		rc(8'h22, 8'h45);
		wr(8'h28, 8'h00);
		rc(8'h28, 8'h9a);
		rc(8'h26, 8'hef);
		rc(8'h27, 8'hbe);
		tdone("receive");
		// Bit timing: prescaler 2, segment one 3
		wr(8'h01, 8'h02);
		wr(8'h02, 8'h03);
		rc(8'h01, 8'h02);
		eng.bit_begin();
		#1;
		for (int i = 0; i < 200 && seg_ticks < 0; i++)
			@(posedge clk_sys_i);
		chk("segment quanta", 8'(seg_ticks), 8'h04);
		chk("quantum clocks", 8'(spacing), 8'h03);
		tdone("timing");
		end_of_test();
	end
endmodule

`default_nettype wire
